// file: hdl/cfsp_top.sv
// Status, interrupt enable and user pointer logic for 32 message FIFOs
`timescale 1ns/1ps
module cfsp_top
  import cfsp_pkg::*;
(
  input  wire logic                pclk,       // Clock, 200 MHz
  input  wire logic                presetn,    // Async reset, active low
  input  wire logic                psel,       // APB select
  input  wire logic                penable,    // APB enable
  input  wire logic                pwrite,     // APB direction
  input  wire logic [11:0]         paddr,      // APB byte address
  input  wire logic [31:0]         pwdata,     // APB write data
  output logic      [31:0]         prdata,     // APB read data
  output logic                     pready,     // APB ready
  output logic                     pslverr,    // APB error
  input  wire logic                cfg_mode,   // Controller in configuration
  input  wire logic                can_rx_evt, // Message stored by engine
  input  wire logic [PTR_W-1:0]    can_rx_sel, // FIFO of stored message
  input  wire logic                can_tx_evt, // Message sent by engine
  input  wire logic [PTR_W-1:0]    can_tx_sel, // FIFO of sent message
  output logic      [NUM_FIFO-1:0] fifo_irq    // Interrupt request per FIFO
);

  // Register map, one 16-byte window per FIFO at FIFO number times 0x10:
  //   +0x0 enables in the upper half, live flags in the lower half
  //   +0x4 user address, read only
  //   +0x8 engine-side message index, read only
  //   +0xC control: direction bit 7, size 20-16, advance bit 13
  // Base address words follow at 0x200, one word per FIFO. Anything at
  // or above 0x280 is refused with pslverr and reads as zero.
  //
  // Bus timing: a transfer is taken at the first edge that sees psel and
  // penable with the handshake idle. The next cycle waits for the base
  // store, whose read data come out of a register; then pready pulses
  // for one cycle with prdata and pslverr beside it. A write lands at
  // the edge that raises pready, so a read right after sees it.
  //
  // Limitations: the base store has no reset, so a user address read
  // before software writes the base word is unknown. A control write
  // in configuration mode empties the FIFO and rewinds its pointers.
  // Direction and size writes outside configuration mode are dropped
  // without an error; the advance bit acts only outside configuration mode.
  //
  // fifo_irq is the OR of every enabled flag of the set direction; it
  // is registered, so it trails the flags by one cycle.

  // State of the block apart from the base store; one packed value, so one always_ff
  // registers it all and reset clears it in one step
  typedef struct packed {
    cfsp_fifo_t [NUM_FIFO-1:0] fifo;
    cfsp_bus_st_t              bus;
    logic [31:0]               rdata;
    logic                      ready;
    logic                      err;
    logic [NUM_FIFO-1:0]       irq;
  } cfsp_state_t;

  cfsp_state_t   st_ff;      // Registered state
  cfsp_state_t   nxt_st;     // Next state
  cfsp_apb_req_t req;        // Bundled bus request
  cfsp_can_evt_t rx_evt;     // Bundled receive event
  cfsp_can_evt_t tx_evt;     // Bundled transmit event
  logic          ram_we;     // Base store write strobe
  logic [PTR_W-1:0] ram_raddr; // Base store read word
  logic [31:0]   ram_rdata_ff; // Base store read data

  // Loose ports bundled so the next-state logic reads one name each
  assign req    = '{psel, penable, pwrite, paddr, pwdata};
  assign rx_evt = '{can_rx_evt, can_rx_sel};
  assign tx_evt = '{can_tx_evt, can_tx_sel};

  // Advance a slot pointer, wrapping after the last slot
  // Wrap is at the size field, so a short FIFO never leaves its slots
  function automatic logic [PTR_W-1:0] ptr_inc(
    input logic [PTR_W-1:0] p,
    input logic [PTR_W-1:0] sz
  );
    ptr_inc = (p == sz) ? '0 : p + 5'h01;
  endfunction

  // Depth from the size field: one to thirty-two messages
  function automatic logic [CNT_W-1:0] depth_of(
    input logic [PTR_W-1:0] sz
  );
    depth_of = {1'b0, sz} + 6'h01;
  endfunction

  // Address lies in the per-FIFO register window
  function automatic logic in_fifo_win(input logic [11:0] a);
    in_fifo_win = (a < FIFO_SPAN_END);
  endfunction

  // Address lies in the base address window
  function automatic logic in_base_win(input logic [11:0] a);
    in_base_win = (a >= BASE_START) && (a < BASE_END);
  endfunction

  // Live level flags; other-direction flags forced to zero.
  // Half is judged on twice the count, so odd depths need no rounding.
  function automatic cfsp_flags_t flags_of(input cfsp_fifo_t f);
    logic [CNT_W-1:0] depth;
    logic [CNT_W:0]   twice;
    depth = depth_of(f.size);
    twice = {f.cnt, 1'b0};
    flags_of = '0;
    if (f.dir) begin
      // Transmit: room, at most half, drained
      flags_of.tx_room_flag    = (f.cnt < depth);
      flags_of.tx_half_flag    = (twice <= {1'b0, depth});
      flags_of.tx_drained_flag = (f.cnt == 6'h00);
    end else begin
      // Receive: overrun, packed, at least half, has a message
      flags_of.rx_overrun_flag = f.ovr;
      flags_of.rx_packed_flag  = (f.cnt == depth);
      flags_of.rx_half_flag    = (twice >= {1'b0, depth});
      flags_of.rx_has_msg_flag = (f.cnt != 6'h00);
    end
  endfunction

  // Assemble the interrupt register read value
  // Enables in the upper half, flags in the lower; the rest reads zero
  function automatic logic [31:0] int_word(input cfsp_fifo_t f);
    cfsp_flags_t fl;
    fl = flags_of(f);
    int_word = RD_ZERO;
    int_word[TX_ROOM_IE_BIT]  = f.irq_en[6];
    int_word[TX_HALF_IE_BIT]  = f.irq_en[5];
    int_word[TX_DRAIN_IE_BIT] = f.irq_en[4];
    int_word[RX_OVR_IE_BIT]   = f.irq_en[3];
    int_word[RX_PACK_IE_BIT]  = f.irq_en[2];
    int_word[RX_HALF_IE_BIT]  = f.irq_en[1];
    int_word[RX_MSG_IE_BIT]   = f.irq_en[0];
    int_word[TX_ROOM_BIT]     = fl.tx_room_flag;
    int_word[TX_HALF_BIT]     = fl.tx_half_flag;
    int_word[TX_DRAIN_BIT]    = fl.tx_drained_flag;
    int_word[RX_OVR_BIT]      = fl.rx_overrun_flag;
    int_word[RX_PACK_BIT]     = fl.rx_packed_flag;
    int_word[RX_HALF_BIT]     = fl.rx_half_flag;
    int_word[RX_MSG_BIT]      = fl.rx_has_msg_flag;
  endfunction

  // Base store read word follows the request address. It is chosen
  // from the setup cycle on, so the registered word is ready by the
  // wait state whichever window the address falls in.
  always_comb begin
    if (in_fifo_win(req.paddr)) begin
      // User address read needs the base word of that FIFO
      ram_raddr = req.paddr[8:4];
    end else begin
      // Base window read returns the word itself
      ram_raddr = req.paddr[6:2];
    end
  end

  // Base store written only on an accepted write to the base window;
  // taking it in the wait state writes each transfer exactly once
  assign ram_we = (st_ff.bus == CFSP_WAIT) && req.pwrite &&
                  in_base_win(req.paddr);

  // Base address words live in their own small memory
  cfsp_base_ram u_base_ram (
    .pclk     (pclk),
    .we       (ram_we),
    .waddr    (req.paddr[6:2]),
    .wdata    (req.pwdata),
    .raddr    (ram_raddr),
    .rdata_ff (ram_rdata_ff)
  );

  // Next-state logic: bus handshake, register effects, FIFO tracking
  always_comb begin
    logic [NUM_FIFO-1:0] sw_adv;    // Software advance per FIFO
    logic [NUM_FIFO-1:0] sw_cfg;    // Software reconfigures FIFO
    logic [PTR_W-1:0]    n;         // Addressed FIFO
    logic                in_fifo;   // Address in per-FIFO window
    logic                in_base;   // Address in base window
    logic [31:0]         slot_off;  // Byte offset of a slot
    logic [PTR_W-1:0]    ua_slot;   // Slot shown as user address
    cfsp_fifo_t          f;         // Working copy of one FIFO
    logic                push;      // One message enters
    logic                pop;       // One message leaves
    logic [CNT_W-1:0]    depth;     // FIFO depth
    sw_adv   = '0;
    sw_cfg   = '0;
    n        = req.paddr[8:4];
    in_fifo  = in_fifo_win(req.paddr);
    in_base  = in_base_win(req.paddr);
    slot_off = '0;
    ua_slot  = '0;
    f        = '0;
    push     = 1'b0;
    pop      = 1'b0;
    depth    = '0;

    // Hold all state by default; answer lines drop after one cycle
    nxt_st   = st_ff;
    nxt_st.ready = 1'b0;
    nxt_st.err   = 1'b0;

    // Bus handshake: wait one cycle for the base store read data.
    // Done holds off a second take while the master still shows the
    // access phase at the edge that samples pready.
    case (st_ff.bus)
      CFSP_IDLE: begin
        // A setup cycle alone is not taken; wait for the access phase
        if (req.psel && req.penable) begin
          nxt_st.bus = CFSP_WAIT;
        end
      end
      CFSP_WAIT: begin
        nxt_st.bus   = CFSP_DONE;
        nxt_st.ready = 1'b1;
        nxt_st.rdata = RD_ZERO;
        // Decode: FIFO registers first, then base words, else refuse
        if (in_fifo) begin
          f = st_ff.fifo[n];
          if (req.paddr[3:2] == REG_INT) begin
            // Interrupt register: enables and live flags
            nxt_st.rdata = int_word(f);
            if (req.pwrite) begin
              // Enables written; overflow flag may only be cleared
              nxt_st.fifo[n].irq_en = {req.pwdata[TX_ROOM_IE_BIT],
                req.pwdata[TX_HALF_IE_BIT], req.pwdata[TX_DRAIN_IE_BIT],
                req.pwdata[RX_OVR_IE_BIT], req.pwdata[RX_PACK_IE_BIT],
                req.pwdata[RX_HALF_IE_BIT], req.pwdata[RX_MSG_IE_BIT]};
              if (!req.pwdata[RX_OVR_BIT]) begin
                nxt_st.fifo[n].ovr = 1'b0;
              end
            end
          end else if (req.paddr[3:2] == REG_UA) begin
            // Head for transmit, tail for receive
            ua_slot  = f.dir ? f.head : f.tail;
            slot_off = {27'h0000000, ua_slot} * MSG_BYTES;
            nxt_st.rdata = (ram_rdata_ff + slot_off) & UA_ALIGN_MASK;
            nxt_st.err   = req.pwrite;
          end else if (req.paddr[3:2] == REG_CI) begin
            // Engine side slot: next sent or next filled
            nxt_st.rdata = {27'h0000000, f.dir ? f.tail : f.head};
            nxt_st.err   = req.pwrite;
          end else begin
            // Control: direction and size read back, advance reads 0
            nxt_st.rdata[DIR_BIT] = f.dir;
            nxt_st.rdata[SIZE_LSB +: PTR_W] = f.size;
            if (req.pwrite) begin
              sw_adv[n] = req.pwdata[ADV_BIT];
              // Shape of a FIFO changes only in configuration
              if (cfg_mode) begin
                sw_cfg[n] = 1'b1;
                nxt_st.fifo[n].dir  = req.pwdata[DIR_BIT];
                nxt_st.fifo[n].size = req.pwdata[SIZE_LSB +: PTR_W];
              end
            end
          end
        end else if (in_base) begin
          // Base word read back; writes go through ram_we
          nxt_st.rdata = ram_rdata_ff;
        end else begin
          nxt_st.err = 1'b1;  // Unmapped address
        end
      end
      CFSP_DONE: begin
        // Answer stood for one cycle; free for the next setup
        nxt_st.bus = CFSP_IDLE;
      end
      default: begin
        // A code that is not one-hot falls back to idle
        nxt_st.bus = CFSP_IDLE;
      end
    endcase

    // Occupancy tracking per FIFO. A transmit FIFO is filled by software
    // at the head and drained by the engine at the tail; a receive FIFO
    // the other way round. A push into a full FIFO or a pop from an
    // empty one is dropped, but a full receive FIFO may store a message
    // in the cycle software frees a slot, as the count stays in range.
    for (int i = 0; i < NUM_FIFO; i++) begin
      f     = st_ff.fifo[i];
      depth = depth_of(f.size);
      push  = 1'b0;
      pop   = 1'b0;
      if (f.dir) begin
        // Software queues at head, engine drains at tail
        push = sw_adv[i] && (f.cnt < depth);
        pop  = tx_evt.evt && (tx_evt.sel == PTR_W'(i)) &&
               (f.cnt != 6'h00);
        if (push) begin
          nxt_st.fifo[i].head = ptr_inc(f.head, f.size);
        end
        if (pop) begin
          nxt_st.fifo[i].tail = ptr_inc(f.tail, f.size);
        end
      end else begin
        // Engine fills at head, software releases at tail
        pop  = sw_adv[i] && (f.cnt != 6'h00);
        push = rx_evt.evt && (rx_evt.sel == PTR_W'(i)) &&
               ((f.cnt < depth) || pop);
        if (rx_evt.evt && (rx_evt.sel == PTR_W'(i)) && !push) begin
          // Set beats a software clear in the same cycle
          nxt_st.fifo[i].ovr = 1'b1;
        end
        if (push) begin
          nxt_st.fifo[i].head = ptr_inc(f.head, f.size);
        end
        if (pop) begin
          nxt_st.fifo[i].tail = ptr_inc(f.tail, f.size);
        end
      end

      // Count moves by one at most; push and pop together leave it
      nxt_st.fifo[i].cnt = f.cnt + {5'h00, push} - {5'h00, pop};

      // Reconfiguring empties the FIFO; stale slots would be wrong
      if (sw_cfg[i]) begin
        nxt_st.fifo[i].head = '0;
        nxt_st.fifo[i].tail = '0;
        nxt_st.fifo[i].cnt  = '0;
        nxt_st.fifo[i].ovr  = 1'b0;
      end

      // Request when any enabled flag of the set direction is one
      // Taken from the present state, so the line trails the flags
      nxt_st.irq[i] = |(flags_of(st_ff.fifo[i]) & st_ff.fifo[i].irq_en);
    end
  end

  // State register; all FIFOs come up as empty receive FIFOs
  // with every enable cleared, so no request rises out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff     <= '0;
      st_ff.bus <= CFSP_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from state flip-flops
  // No logic sits between the state register and a port
  assign prdata   = st_ff.rdata;
  assign pready   = st_ff.ready;
  assign pslverr  = st_ff.err;
  assign fifo_irq = st_ff.irq;

endmodule

// file: hdl/cfsp_pkg.sv
// Constants and types shared by the FIFO status and pointer block
package cfsp_pkg;

  // Number of FIFOs and pointer widths
  localparam int unsigned NUM_FIFO  = 32;
  localparam int unsigned PTR_W     = 5;
  localparam int unsigned CNT_W     = 6;

  // Per-FIFO register window: 16 bytes per FIFO
  localparam logic [11:0] FIFO_SPAN_END = 12'h200;
  localparam logic [1:0]  REG_INT       = 2'h0;
  localparam logic [1:0]  REG_UA        = 2'h1;
  localparam logic [1:0]  REG_CI        = 2'h2;
  localparam logic [1:0]  REG_CTRL      = 2'h3;
  // Message buffer base address words, one per FIFO
  localparam logic [11:0] BASE_START    = 12'h200;
  localparam logic [11:0] BASE_END      = 12'h280;

  // Bytes taken by one message in system memory
  localparam logic [31:0] MSG_BYTES     = 32'h0000_0010;

  // Interrupt register field positions
  localparam int unsigned TX_ROOM_IE_BIT   = 26;
  localparam int unsigned TX_HALF_IE_BIT   = 25;
  localparam int unsigned TX_DRAIN_IE_BIT  = 24;
  localparam int unsigned RX_OVR_IE_BIT    = 19;
  localparam int unsigned RX_PACK_IE_BIT   = 18;
  localparam int unsigned RX_HALF_IE_BIT   = 17;
  localparam int unsigned RX_MSG_IE_BIT    = 16;
  localparam int unsigned TX_ROOM_BIT      = 10;
  localparam int unsigned TX_HALF_BIT      = 9;
  localparam int unsigned TX_DRAIN_BIT     = 8;
  localparam int unsigned RX_OVR_BIT       = 3;
  localparam int unsigned RX_PACK_BIT      = 2;
  localparam int unsigned RX_HALF_BIT      = 1;
  localparam int unsigned RX_MSG_BIT       = 0;

  // Control register field positions
  localparam int unsigned DIR_BIT          = 7;
  localparam int unsigned ADV_BIT          = 13;
  localparam int unsigned SIZE_LSB         = 16;

  // Low address bits forced to zero on user address reads
  localparam logic [31:0] UA_ALIGN_MASK    = 32'hFFFF_FFFC;

  // Reset values
  localparam logic [31:0] RD_ZERO          = 32'h0000_0000;

  // Bus handshake states, one-hot
  typedef enum logic [2:0] {
    CFSP_IDLE = 3'b001,
    CFSP_WAIT = 3'b010,
    CFSP_DONE = 3'b100
  } cfsp_bus_st_t;

  // Flags of one FIFO, transmit and receive
  typedef struct packed {
    logic tx_room_flag;
    logic tx_half_flag;
    logic tx_drained_flag;
    logic rx_overrun_flag;
    logic rx_packed_flag;
    logic rx_half_flag;
    logic rx_has_msg_flag;
  } cfsp_flags_t;

  // State kept for one FIFO
  typedef struct packed {
    logic              dir;     // fifo_direction_select: 1 transmit
    logic [PTR_W-1:0]  size;    // Depth minus one
    logic [6:0]        irq_en;  // Enables in cfsp_flags_t order
    logic              ovr;     // Sticky receive overflow
    logic [PTR_W-1:0]  head;    // Slot written next
    logic [PTR_W-1:0]  tail;    // Slot read next
    logic [CNT_W-1:0]  cnt;     // Messages held
  } cfsp_fifo_t;

  // APB request carried into the block
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cfsp_apb_req_t;

  // Events from the protocol side
  typedef struct packed {
    logic             evt;   // One-cycle message event
    logic [PTR_W-1:0] sel;   // FIFO the event belongs to
  } cfsp_can_evt_t;

endpackage

// file: hdl/cfsp_base_ram.sv
// Base address store, one word per FIFO, registered read data
`timescale 1ns/1ps
module cfsp_base_ram
  import cfsp_pkg::*;
(
  input  wire logic             pclk,    // Clock
  input  wire logic             we,      // Write strobe
  input  wire logic [PTR_W-1:0] waddr,   // Write word
  input  wire logic [31:0]      wdata,   // Write data
  input  wire logic [PTR_W-1:0] raddr,   // Read word
  output logic      [31:0]      rdata_ff // Read data, one cycle late
);

  logic [31:0] mem [NUM_FIFO];  // No reset: contents are unknown at start

  // Write and read port, read data from a register
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_ff <= mem[raddr];
  end

endmodule

// file: test/cfsp_top_props.sv
// Bus timing and register read-back checks at the block's ports
`timescale 1ns/1ps
module cfsp_top_props
  import cfsp_pkg::*;
(
  input wire logic                pclk,       // Clock
  input wire logic                presetn,    // Async reset, active low
  input wire logic                psel,       // APB select
  input wire logic                penable,    // APB enable
  input wire logic                pwrite,     // APB direction
  input wire logic [11:0]         paddr,      // APB byte address
  input wire logic [31:0]         pwdata,     // APB write data
  input wire logic [31:0]         prdata,     // APB read data
  input wire logic                pready,     // APB ready
  input wire logic                pslverr,    // APB error
  input wire logic                cfg_mode,   // Configuration mode
  input wire logic                can_rx_evt, // Message stored
  input wire logic [PTR_W-1:0]    can_rx_sel, // FIFO of stored message
  input wire logic                can_tx_evt, // Message sent
  input wire logic [PTR_W-1:0]    can_tx_sel, // FIFO of sent message
  input wire logic [NUM_FIFO-1:0] fifo_irq    // Interrupt per FIFO
);
  logic rd_fifo; // Read answer from a per-FIFO register
  logic wr_fifo; // Write answer to a per-FIFO register
  assign rd_fifo = pready && !pwrite && (paddr < FIFO_SPAN_END);
  assign wr_fifo = pready && pwrite && (paddr < FIFO_SPAN_END);

  // One clock domain, so one default clock and reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Answer comes exactly two edges after the access phase opens
  a_ready_latency: assert property ($rose(penable) && psel |->
    !pready ##1 !pready ##1 pready) else $error("pready late or early");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (pready && paddr >= BASE_END |->
    pslverr && prdata == RD_ZERO) else $error("unmapped not refused");
  a_ro_write_err: assert property (wr_fifo && (paddr[3:2] == REG_UA ||
    paddr[3:2] == REG_CI) |-> pslverr) else $error("ro write taken");
  a_ua_align: assert property (rd_fifo && paddr[3:2] == REG_UA |->
    prdata[1:0] == 2'h0) else $error("user address unaligned");
  a_index_width: assert property (rd_fifo && paddr[3:2] == REG_CI |->
    prdata[31:5] == 27'h0) else $error("index upper bits set");
  a_int_unimpl: assert property (rd_fifo && paddr[3:2] == REG_INT |->
    (prdata & 32'hF8F0_F8F0) == RD_ZERO) else $error("unused bits");
  // A FIFO has one direction, so both flag groups never show together
  a_dir_excl: assert property (rd_fifo && paddr[3:2] == REG_INT |->
    !(|prdata[10:8] && |prdata[3:0])) else $error("mixed flags");
  a_tx_levels: assert property (rd_fifo && paddr[3:2] == REG_INT &&
    prdata[8] |-> prdata[10] && prdata[9]) else $error("tx levels");
  a_rx_levels: assert property (rd_fifo && paddr[3:2] == REG_INT &&
    prdata[2] |-> prdata[1] && prdata[0]) else $error("rx levels");
endmodule

bind cfsp_top cfsp_top_props i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cfg_mode(cfg_mode), .can_rx_evt(can_rx_evt), .can_rx_sel(can_rx_sel),
  .can_tx_evt(can_tx_evt), .can_tx_sel(can_tx_sel), .fifo_irq(fifo_irq));

// file: test/test_cfsp_top.sv
// Self-checking bench for the FIFO status and pointer block
`timescale 1ns/1ps
module test_cfsp_top;
  import cfsp_pkg::*;
  logic                pclk;       // Clock, 5 ns
  logic                presetn;    // Reset, active low
  logic                psel;       // APB select
  logic                penable;    // APB enable
  logic                pwrite;     // APB direction
  logic [11:0]         paddr;      // APB address
  logic [31:0]         pwdata;     // APB write data
  logic [31:0]         prdata;     // APB read data
  logic                pready;     // APB ready
  logic                pslverr;    // APB error
  logic                cfg_mode;   // Configuration mode
  logic                can_rx_evt; // Store event
  logic [PTR_W-1:0]    can_rx_sel; // Store FIFO
  logic                can_tx_evt; // Send event
  logic [PTR_W-1:0]    can_tx_sel; // Send FIFO
  logic [NUM_FIFO-1:0] fifo_irq;   // Interrupts
  logic [31:0]         rd;         // Last read data
  logic                err;        // Last error response
  int                  errors;     // Mismatches
  int                  cmp_count;  // Comparisons
  int                  cyc;        // Cycles for the timeout

  cfsp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg_mode(cfg_mode), .can_rx_evt(can_rx_evt), .can_rx_sel(can_rx_sel),
    .can_tx_evt(can_tx_evt), .can_tx_sel(can_tx_sel), .fifo_irq(fifo_irq));

  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then stops
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // Compares one 32-bit result
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No limit here: a slave that never answers ends in the timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read and compare in one step
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
                       input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  // One-cycle engine event: store when rx is high, send otherwise
  task automatic evt(input logic rx, input logic [PTR_W-1:0] s);
    @(posedge pclk);
    can_rx_evt <= rx;
    can_tx_evt <= !rx;
    can_rx_sel <= s;
    can_tx_sel <= s;
    @(posedge pclk);
    can_rx_evt <= 1'b0;
    can_tx_evt <= 1'b0;
  endtask

  // Reset state and refused accesses
  task automatic t_reset();
    rdchk(12'h000, 32'h0000_0000, "int0 reset");
    rdchk(12'h008, 32'h0000_0000, "index0 reset");
    apb(1'b0, 12'h280, 32'h0000_0000);
    chk("unmapped data", 32'h0000_0000, rd);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    chk("ua write err", 32'h0000_0001, {31'h0, err});
    $display("test reset done");
  endtask

  // Transmit FIFO 1, depth 4: fill by software advance, drain by engine
  task automatic t_tx();
    logic [31:0] fl [5] = '{32'h600, 32'h600, 32'h400, 32'h0, 32'h0};
    logic [31:0] ua [5] = '{32'h1010, 32'h1020, 32'h1030, 32'h1000,
                            32'h1000};
    @(posedge pclk);
    cfg_mode <= 1'b1;
    apb(1'b1, 12'h01C, 32'h0003_0080);
    apb(1'b1, 12'h204, 32'h0000_1003);
    cfg_mode <= 1'b0;
    apb(1'b1, 12'h010, 32'h0700_0000);
    rdchk(12'h010, 32'h0700_0700, "tx empty");
    chk("irq1 on", 32'h1, {31'h0, fifo_irq[1]});
    rdchk(12'h014, 32'h0000_1000, "tx ua");
    // Fifth advance hits a full FIFO and must change nothing
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, 12'h01C, 32'h0000_2000);
      rdchk(12'h010, 32'h0700_0000 | fl[k], "tx flags");
      rdchk(12'h014, ua[k], "tx ua step");
    end
    chk("irq1 full", 32'h0, {31'h0, fifo_irq[1]});
    evt(1'b0, 5'h01);
    rdchk(12'h010, 32'h0700_0400, "tx sent");
    rdchk(12'h018, 32'h0000_0001, "tx index");
    $display("test tx done");
  endtask

  // Receive FIFO 2, depth 2: fill, overflow, release, clear
  task automatic t_rx();
    @(posedge pclk);
    cfg_mode <= 1'b1;
    apb(1'b1, 12'h02C, 32'h0001_0000);
    apb(1'b1, 12'h208, 32'h0000_2000);
    cfg_mode <= 1'b0;
    apb(1'b1, 12'h020, 32'h000F_0000);
    rdchk(12'h020, 32'h000F_0000, "rx empty");
    chk("irq2 off", 32'h0, {31'h0, fifo_irq[2]});
    evt(1'b1, 5'h02);
    rdchk(12'h020, 32'h000F_0003, "rx one");
    rdchk(12'h028, 32'h0000_0001, "rx index");
    evt(1'b1, 5'h02);
    rdchk(12'h020, 32'h000F_0007, "rx full");
    evt(1'b1, 5'h02);
    rdchk(12'h020, 32'h000F_000F, "rx overrun");
    rdchk(12'h024, 32'h0000_2000, "rx ua");
    apb(1'b1, 12'h02C, 32'h0000_2000);
    rdchk(12'h024, 32'h0000_2010, "rx ua step");
    rdchk(12'h020, 32'h000F_000B, "rx released");
    apb(1'b1, 12'h020, 32'hFFFF_FFF7);
    rdchk(12'h020, 32'h070F_0003, "rx cleared");
    // Direction write outside configuration must be dropped
    apb(1'b1, 12'h02C, 32'h0000_0080);
    rdchk(12'h02C, 32'h0001_0000, "rx dir kept");
    chk("irq2 on", 32'h1, {31'h0, fifo_irq[2]});
    $display("test rx done");
  endtask

  // Main sequence
  initial begin
    {psel, penable, pwrite, cfg_mode, can_rx_evt, can_tx_evt} = 6'h00;
    {paddr, pwdata, can_rx_sel, can_tx_sel} = 54'h0;
    presetn = 1'b0;
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    wrap_up();
  end
endmodule
